// ==== rtl/pptb_top.sv ====
/*
  power pwm time base with three duty generators, six outputs and dead time.
  assumes an axi4-lite master on aclk, one access of each kind at a time.
*/
// Function
// R1 - three duty generators drive six outputs as even/odd pairs
// R2 - complementary pair: even output is complement of odd output
// R3 - complementary: even never forced active while odd is active
// R4 - complementary: even goes inactive, dead time, then odd active
// R5 - dead time inserts programmable interval with both pins off
// R6 - time base is 12-bit counter with prescaler and postscaler
// R7 - run bit 7 of run register starts and stops time base
// R8 - clearing run bit holds the count, never clears it
// R9 - mode bits 1-0 select free, single-shot, up/down, up/down double
// R10 - free and single-shot edge-aligned; up/down modes center-aligned; the code drives up/down pulses only while counting down
// R11 - prescale bits 3-2 divide by 4, 16, 64 or 256 of oscillator
// R12 - postscale bits 7-4 divide match events by value plus one; the code ignores the postscaler in single-shot mode
// R13 - read-only direction flag bit 6 reads 1 counting down; 5-0 zero
// R14 - count, period, special compare and duties are double-buffered 16-bit; the code writes the 12-bit count directly
// R15 - duty resolution up to 14 bits depending on period
// R16 - debug mode forces all pulse outputs inactive
// R17 - free-running: count to period, reset next input clock, keep running
// R18 - single-shot: period match resets count and hardware clears run bit
// R19 - up/down: after period count down next edge, flag set while down
// R20 - prescaler cleared on count write, control writes and reset
`timescale 1ns/10ps
`default_nettype none
`include "pptb_cfg.svh"

module pptb_top
  import pptb_pkg::*;
#(
  parameter int CNT_W = 12,
  parameter int DUTY_W = 14
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic debug_mode,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [5:0] pulse_out,
  output logic match_event
);

  // ----------------------------------------------------------------------
  // axi4-lite write side
  // ----------------------------------------------------------------------
  logic [7:0] aw_addr;
  wire aw_full = !s_axi_awready;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire w_full = !s_axi_wready;
  wire do_write = aw_full && w_full && !s_axi_bvalid;
  wire [7:0] wa = aw_addr;
  wire wr_mode = do_write && wa == `PPTB_OFS_MODE;
  wire wr_run = do_write && wa == `PPTB_OFS_RUN;
  wire wr_count = do_write && wa == `PPTB_OFS_COUNT;
  wire wr_period = do_write && wa == `PPTB_OFS_PERIOD;
  wire wr_sevt = do_write && wa == `PPTB_OFS_SEVT;
  wire wr_duty0 = do_write && wa == `PPTB_OFS_DUTY0;
  wire wr_duty1 = do_write && wa == `PPTB_OFS_DUTY1;
  wire wr_duty2 = do_write && wa == `PPTB_OFS_DUTY2;
  wire wr_pair = do_write && wa == `PPTB_OFS_PAIR;
  wire wr_dead = do_write && wa == `PPTB_OFS_DEAD;
  wire wr_known = wr_mode || wr_run || wr_count || wr_period || wr_sevt || wr_duty0
    || wr_duty1 || wr_duty2 || wr_pair || wr_dead;
  wire [15:0] wd16 = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  logic [7:0] mode_reg;
  logic run;
  logic [15:0] period_buf, period_act, sevt_buf, sevt_act;
  logic [15:0] duty_buf [3];
  logic [15:0] duty_act [3];
  logic [2:0] indep;
  logic [7:0] dead_time;
  logic [CNT_W-1:0] count;
  logic down;
  wire pptb_mode_t mode = pptb_mode_t'(mode_reg[`PPTB_MODE_LO +: 2]); // R9
  wire [1:0] pre_sel = mode_reg[`PPTB_PRE_LO +: 2];
  wire [3:0] post_sel = mode_reg[`PPTB_POST_LO +: 4];
  wire center = mode == PPTB_UPDN || mode == PPTB_UPDN_DBL; // R10
  wire [CNT_W-1:0] per = period_act[CNT_W-1:0];

  // ----------------------------------------------------------------------
  // prescaler: fosc/4 base, then 1, 4, 16 or 64
  // ----------------------------------------------------------------------
  logic [7:0] pre_cnt;
  wire [7:0] pre_top = (pre_sel == 2'h0) ? 8'h03 : (pre_sel == 2'h1) ? 8'h0F
    : (pre_sel == 2'h2) ? 8'h3F : 8'hFF; // R11
  wire tick = run && pre_cnt == pre_top;
  wire pre_clr = wr_count || wr_mode || wr_run; // R20
  always_ff @(posedge aclk) begin
    if (!aresetn || pre_clr) pre_cnt <= 8'h00; // R20
    else if (run) pre_cnt <= tick ? 8'h00 : pre_cnt + 8'h01;
  end

  // ----------------------------------------------------------------------
  // time base counter
  // ----------------------------------------------------------------------
  wire at_per = count == per;
  wire at_zero = count == '0;
  // period boundary is where shadows load so edges never glitch
  wire load_shadow = tick && (center ? (at_zero && down) : at_per); // R14
  wire match = tick && (center ? (at_zero && down) : at_per);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      down <= 1'b0;
      run <= 1'b0;
      mode_reg <= `PPTB_RST_MODE;
    end else begin
      if (wr_mode) mode_reg <= wd16[7:0];
      if (wr_run) run <= wd16[`PPTB_RUN_BIT]; // R7
      if (wr_count) count <= wd16[CNT_W-1:0];
      else if (tick) begin // R6 R8
        if (!center) begin
          down <= 1'b0;
          if (at_per) begin
            count <= '0; // R17
            if (mode == PPTB_SHOT) run <= 1'b0; // R18
          end else count <= count + 1'b1;
        end else if (!down) begin
          if (at_per) begin
            down <= 1'b1; // R19
            count <= count - 1'b1;
          end else count <= count + 1'b1;
        end else if (at_zero) begin
          down <= 1'b0;
          count <= count + 1'b1;
        end else count <= count - 1'b1; // R19
      end
    end
  end

  // ----------------------------------------------------------------------
  // postscaler on match events
  // ----------------------------------------------------------------------
  logic [3:0] post_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || pre_clr) begin // R20
      post_cnt <= 4'h0;
      match_event <= 1'b0;
    end else begin
      match_event <= 1'b0;
      if (match) begin
        if (mode == PPTB_SHOT || post_cnt == post_sel) begin // R12
          post_cnt <= 4'h0;
          match_event <= 1'b1;
        end else post_cnt <= post_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // double-buffered value registers, with pair and dead time registers written directly
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_buf <= `PPTB_RST_PERIOD;
      period_act <= `PPTB_RST_PERIOD;
      sevt_buf <= `PPTB_RST_DUTY;
      sevt_act <= `PPTB_RST_DUTY;
      indep <= `PPTB_RST_PAIR;
      dead_time <= `PPTB_RST_DEAD;
      for (int i = 0; i < 3; i++) begin
        duty_buf[i] <= `PPTB_RST_DUTY;
        duty_act[i] <= `PPTB_RST_DUTY;
      end
    end else begin
      if (wr_period) period_buf <= wd16; // R14
      if (wr_sevt) sevt_buf <= wd16;
      if (wr_duty0) duty_buf[0] <= wd16;
      if (wr_duty1) duty_buf[1] <= wd16;
      if (wr_duty2) duty_buf[2] <= wd16;
      if (wr_pair) indep <= wd16[2:0];
      if (wr_dead) dead_time <= wd16[7:0];
      if (load_shadow || !run) begin // R14
        period_act <= period_buf;
        sevt_act <= sevt_buf;
        for (int i = 0; i < 3; i++) duty_act[i] <= duty_buf[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // duty compare: duty has two fraction bits below the count (R15)
  // ----------------------------------------------------------------------
  logic [DUTY_W-1:0] fine;
  assign fine = {count, pre_cnt[1:0]};
  logic [2:0] raw;
  always_comb begin
    for (int g = 0; g < 3; g++) begin // R1
      raw[g] = center ? (down && fine < duty_act[g][DUTY_W-1:0]) // R10
        : (fine < duty_act[g][DUTY_W-1:0]); // R15
    end
  end

  // ----------------------------------------------------------------------
  // pair output stage with dead time
  // ----------------------------------------------------------------------
  pptb_pair_t pst [3];
  logic [7:0] dcnt [3];
  logic [2:0] dead_to_odd;
  logic [5:0] next_out;
  always_ff @(posedge aclk) begin
    for (int g = 0; g < 3; g++) begin
      if (!aresetn) begin
        pst[g] <= PPTB_ST_OFF;
        dcnt[g] <= 8'h00;
        dead_to_odd[g] <= 1'b0;
      end else begin
        case (pst[g])
          PPTB_ST_ODD, PPTB_ST_EVEN, PPTB_ST_OFF: begin
            if (pst[g] != PPTB_ST_ODD && raw[g]) begin
              pst[g] <= PPTB_ST_DEAD; // R4
              dead_to_odd[g] <= 1'b1;
              dcnt[g] <= dead_time;
            end else if (pst[g] != PPTB_ST_EVEN && !raw[g]) begin
              pst[g] <= PPTB_ST_DEAD; // R5
              dead_to_odd[g] <= 1'b0;
              dcnt[g] <= dead_time;
            end
          end
          PPTB_ST_DEAD: begin
            if (dcnt[g] == 8'h00) pst[g] <= dead_to_odd[g] ? PPTB_ST_ODD : PPTB_ST_EVEN;
            else dcnt[g] <= dcnt[g] - 8'h01; // R5
          end
          default: pst[g] <= PPTB_ST_OFF;
        endcase
      end
    end
  end
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      if (indep[g]) begin
        next_out[2*g] = raw[g];
        next_out[2*g+1] = raw[g];
      end else begin
        next_out[2*g+1] = pst[g] == PPTB_ST_ODD; // R2
        next_out[2*g] = pst[g] == PPTB_ST_EVEN; // R3
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || debug_mode) pulse_out <= 6'h00; // R16
    else pulse_out <= next_out;
  end

  // ----------------------------------------------------------------------
  // axi4-lite read side
  // ----------------------------------------------------------------------
  wire [7:0] ra = s_axi_araddr[7:0];
  logic [31:0] rd;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (ra)
      `PPTB_OFS_MODE: rd = {24'h00_0000, mode_reg};
      `PPTB_OFS_RUN: rd = {24'h00_0000, run, down, 6'h00}; // R13
      `PPTB_OFS_COUNT: rd = {20'h0_0000, count};
      `PPTB_OFS_PERIOD: rd = {16'h0000, period_buf};
      `PPTB_OFS_SEVT: rd = {16'h0000, sevt_buf};
      `PPTB_OFS_DUTY0: rd = {16'h0000, duty_buf[0]};
      `PPTB_OFS_DUTY1: rd = {16'h0000, duty_buf[1]};
      `PPTB_OFS_DUTY2: rd = {16'h0000, duty_buf[2]};
      `PPTB_OFS_PAIR: rd = {29'h0000_0000, indep};
      `PPTB_OFS_DEAD: rd = {24'h00_0000, dead_time};
      default: begin
        rd = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= rd;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : pptb_top
`default_nettype wire

// ==== common/pptb_cfg.svh ====
/*
  register offsets, field positions, reset values and timing counts of the
  power pwm time base. assumes inclusion by bare name from the design files.
*/
`ifndef PPTB_CFG_SVH
`define PPTB_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PPTB_OFS_MODE 8'h00
`define PPTB_OFS_RUN 8'h04
`define PPTB_OFS_COUNT 8'h08
`define PPTB_OFS_PERIOD 8'h0C
`define PPTB_OFS_SEVT 8'h10
`define PPTB_OFS_DUTY0 8'h14
`define PPTB_OFS_DUTY1 8'h18
`define PPTB_OFS_DUTY2 8'h1C
`define PPTB_OFS_PAIR 8'h20
`define PPTB_OFS_DEAD 8'h24
`define PPTB_OFS_EVENT 8'h28

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PPTB_MODE_LO 0
`define PPTB_PRE_LO 2
`define PPTB_POST_LO 4
`define PPTB_RUN_BIT 7
`define PPTB_DIR_BIT 6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PPTB_RST_MODE 8'h00
`define PPTB_RST_PERIOD 16'h0000
`define PPTB_RST_DUTY 16'h0000
`define PPTB_RST_PAIR 3'h0
`define PPTB_RST_DEAD 8'h00

// ----------------------------------------------------------------------
// timing: instruction clock is the system clock over four
// ----------------------------------------------------------------------
`define PPTB_FOSC_DIV 4

`endif

// ==== common/pptb_pkg.sv ====
/*
  types of the power pwm time base.
  assumes nothing of its surroundings.
*/
package pptb_pkg;

  // ----------------------------------------------------------------------
  // counting modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PPTB_FREE = 2'h0,
    PPTB_SHOT = 2'h1,
    PPTB_UPDN = 2'h2,
    PPTB_UPDN_DBL = 2'h3
  } pptb_mode_t;

  // one-hot pair output states
  typedef enum logic [3:0] {
    PPTB_ST_OFF = 4'h1,
    PPTB_ST_ODD = 4'h2,
    PPTB_ST_DEAD = 4'h4,
    PPTB_ST_EVEN = 4'h8
  } pptb_pair_t;

endpackage : pptb_pkg

// ==== bench/pptb_top_properties.sv ====
/*
  concurrent checks on the ports of the pwm time base.
  assumes binding to pptb_top and every pair left complementary.
*/
`timescale 1ns/10ps
`default_nettype none

module pptb_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic debug_mode,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] pulse_out,
  input wire logic match_event
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------------
  // pair outputs
  // ----------------------------------------------------------------------
  property p_no_overlap;
    pulse_out[1:0] != 2'h3 && pulse_out[3:2] != 2'h3 && pulse_out[5:4] != 2'h3;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pair both on");
  property p_dead_odd;
    $rose(pulse_out[1]) |-> !$past(pulse_out[0]) && !pulse_out[0];
  endproperty
  a_dead_odd: assert property (p_dead_odd) else $error("odd on without gap");
  property p_dead_even;
    $rose(pulse_out[0]) |-> !$past(pulse_out[1]);
  endproperty
  a_dead_even: assert property (p_dead_even) else $error("even on without gap");
  property p_debug;
    debug_mode |=> pulse_out == 6'h00;
  endproperty
  a_debug: assert property (p_debug) else $error("outputs on in debug");
  // one tick is at least four clocks, so events cannot crowd closer
  property p_match_gap;
    match_event |=> !match_event [*3];
  endproperty
  a_match_gap: assert property (p_match_gap) else $error("events too close");

  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer moved");
  property p_rnext;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rnext: assert property (p_rnext) else $error("read answer late");
  property p_arready;
    s_axi_arready == !s_axi_rvalid;
  endproperty
  a_arready: assert property (p_arready) else $error("arready wrong");

  c_match: cover property (match_event);
  c_odd: cover property ($rose(pulse_out[1]));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : pptb_checker

bind pptb_top pptb_checker u_chk (.*);

`default_nettype wire

// ==== bench/pptb_bridge_model.sv ====
/*
  half-bridge load on the six pulse outputs.
  assumes pulse_out is active high, pairs are bits 2g and 2g+1.
*/
`timescale 1ns/10ps
`default_nettype none

module pptb_bridge_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] pulse_out,
  output logic [5:0] gate_seen,
  output logic shoot_thru
);
  // sticky records: a switch that never closed means a dead generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_seen <= 6'h00;
      shoot_thru <= 1'h0;
    end else begin
      gate_seen <= gate_seen | pulse_out;
      shoot_thru <= shoot_thru | (&pulse_out[1:0]) | (&pulse_out[3:2]) | (&pulse_out[5:4]);
    end
  end
endmodule : pptb_bridge_model

`default_nettype wire

// ==== bench/pptb_top_tb.sv ====
/*
  self-checking bench for the pwm time base.
  assumes the register map of pptb_cfg.svh and pairs left complementary.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pptb_cfg.svh"

module pptb_top_tb;
  import pptb_pkg::*;
  logic aclk, aresetn, debug_mode;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, match_event, shoot_thru;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] pulse_out, gate_seen;
  int fail_count, checks_done;
  logic [1:0] wr_resp;

  pptb_top uut (.*);
  pptb_bridge_model u_load (.aclk(aclk), .aresetn(aresetn), .pulse_out(pulse_out),
    .gate_seen(gate_seen), .shoot_thru(shoot_thru));

  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic hang();
    fail_count++;
    finish_test();
  endtask : hang

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask : chk

  // ready is sampled mid-cycle and acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, bd;
    n = 0;
    bd = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!bd && n < 64) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bd = s_axi_bvalid;
      wr_resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      n++;
    end
    s_axi_bready <= 1'h0;
    if (!bd) hang();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, got;
    n = 0;
    got = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= {24'h00_0000, a};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!got && n < 64) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      n++;
    end
    s_axi_rready <= 1'h0;
    if (!got) hang();
  endtask : rd

  task automatic wait_ev(output int c);
    c = 0;
    do begin
      @(negedge aclk);
      c++;
    end while (!match_event && c < 3000);
    if (c >= 3000) hang();
  endtask : wait_ev

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd(`PPTB_OFS_MODE, d, r);
    chk(d, 32'h0000_0000);
    rd(`PPTB_OFS_RUN, d, r);
    chk(d, 32'h0000_0000);
    rd(8'h3C, d, r);
    chk({30'h0, r}, 32'h0000_0002);
    wr(8'h3C, 32'h0000_0000);
    chk({30'h0, wr_resp}, 32'h0000_0002);
    wr(`PPTB_OFS_DEAD, 32'h0000_0000);
    chk({30'h0, wr_resp}, 32'h0000_0000);
  endtask : t_reset

  // period 3 gives four ticks per cycle; tick is four clocks times prescale
  task automatic t_rate();
    logic [7:0] cfg [4] = '{8'h00, 8'h04, 8'h10, 8'hF0};
    int exp [4] = '{16, 64, 32, 256};
    int c;
    wr(`PPTB_OFS_PERIOD, 32'h0000_0003);
    wr(`PPTB_OFS_DUTY0, 32'h0000_0008);
    wr(`PPTB_OFS_DUTY1, 32'h0000_0008);
    wr(`PPTB_OFS_DUTY2, 32'h0000_0008);
    for (int i = 0; i < 4; i++) begin
      wr(`PPTB_OFS_MODE, {24'h00_0000, cfg[i]});
      wr(`PPTB_OFS_RUN, 32'h0000_0080);
      wait_ev(c);
      wait_ev(c);
      chk(32'(c), 32'(exp[i]));
    end
    chk({26'h0, gate_seen}, 32'h0000_003F);
    chk({31'h0, shoot_thru}, 32'h0000_0000);
  endtask : t_rate

  task automatic t_hold();
    logic [31:0] a, b;
    logic [1:0] r;
    wr(`PPTB_OFS_RUN, 32'h0000_0000);
    rd(`PPTB_OFS_COUNT, a, r);
    repeat (100) @(posedge aclk);
    rd(`PPTB_OFS_COUNT, b, r);
    chk(b, a);
  endtask : t_hold

  task automatic t_shot();
    logic [31:0] d;
    logic [1:0] r;
    int c;
    wr(`PPTB_OFS_MODE, {30'h0, PPTB_SHOT});
    wr(`PPTB_OFS_RUN, 32'h0000_0080);
    wait_ev(c);
    repeat (2) @(posedge aclk);
    rd(`PPTB_OFS_RUN, d, r);
    chk(d, 32'h0000_0000);
    rd(`PPTB_OFS_COUNT, d, r);
    chk(d, 32'h0000_0000);
  endtask : t_shot

  task automatic t_updn();
    pptb_mode_t m [2] = '{PPTB_UPDN, PPTB_UPDN_DBL};
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(`PPTB_OFS_PERIOD, 32'h0000_0008);
    for (int i = 0; i < 2; i++) begin
      wr(`PPTB_OFS_MODE, {30'h0, m[i]});
      wr(`PPTB_OFS_RUN, 32'h0000_0080);
      n = 0;
      do begin
        rd(`PPTB_OFS_RUN, d, r);
        n++;
      end while (!d[6] && n < 200);
      chk(d, 32'h0000_00C0);
      do begin
        rd(`PPTB_OFS_RUN, d, r);
        n++;
      end while (d[6] && n < 400);
      chk(d, 32'h0000_0080);
      wr(`PPTB_OFS_RUN, 32'h0000_0000);
    end
  endtask : t_updn

  task automatic t_debug();
    logic [5:0] acc;
    acc = 6'h00;
    wr(`PPTB_OFS_MODE, 32'h0000_0000);
    wr(`PPTB_OFS_RUN, 32'h0000_0080);
    repeat (40) @(posedge aclk);
    debug_mode <= 1'h1;
    repeat (3) @(posedge aclk);
    repeat (40) begin
      @(negedge aclk);
      acc = acc | pulse_out;
    end
    chk({26'h0, acc}, 32'h0000_0000);
    @(posedge aclk);
    debug_mode <= 1'h0;
  endtask : t_debug

  // write lands two edges after the request; a count write restarts the prescaler,
  // so the match comes one full tick later; a new period only counts from the boundary
  task automatic t_buffer();
    logic [31:0] d;
    logic [1:0] r;
    int c;
    wr(`PPTB_OFS_RUN, 32'h0000_0000);
    wr(`PPTB_OFS_COUNT, 32'h0000_FFFF);
    rd(`PPTB_OFS_COUNT, d, r);
    chk(d, 32'h0000_0FFF);
    wr(`PPTB_OFS_RUN, 32'h0000_0080);
    wr(`PPTB_OFS_COUNT, 32'h0000_0008);
    wait_ev(c);
    chk(32'(c), `PPTB_FOSC_DIV);
    wr(`PPTB_OFS_PERIOD, 32'h0000_0003);
    wait_ev(c);
    chk(32'(c), 32'h0000_0021);
    wait_ev(c);
    chk(32'(c), 32'h0000_0010);
  endtask : t_buffer

  initial begin
    fail_count = 0;
    checks_done = 0;
    {aresetn, debug_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 32'h0000_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_araddr = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_rate();
    t_hold();
    t_shot();
    t_updn();
    t_debug();
    t_buffer();
    finish_test();
  end
endmodule : pptb_top_tb

`default_nettype wire
